// ===== design/pxg_map.svh
// Purpose: Constants for the 64-bit client bus and the gearbox-side transceiver words
// Assumes: One 64-bit beat carries two 32-bit transfers; lane n is bits 8n+7:8n
// Notes:   Counts are in system clock cycles or in valid receive beats, as named
`ifndef PXG_MAP_SVH
`define PXG_MAP_SVH

// Bus widths and lane layout
`define PXG_XFER_W        32
`define PXG_WORD_W        64
`define PXG_LANES         8
`define PXG_LANE_W        8
`define PXG_XCTL_W        8

// Client control characters (valid only with the lane control bit set)
`define PXG_CH_IDLE       8'h07
`define PXG_CH_START      8'hFB
`define PXG_CH_TERM       8'hFD
`define PXG_CH_ERROR      8'hFE
`define PXG_START_LANE_LO 3'h0
`define PXG_START_LANE_HI 3'h4

// Transceiver control field positions
`define PXG_HDR_LSB       0
`define PXG_HDR_MSB       1
`define PXG_SEQ_LSB       2
`define PXG_SEQ_MSB       7
`define PXG_RXVALID_BIT   2
`define PXG_HDR_DATA      2'h1
`define PXG_HDR_CTRL      2'h2

// Gearbox sequence and valid cadence
`define PXG_SEQ_MAX       6'h20
`define PXG_VALID_MAX     6'h20

// Block lock timing, in valid beats except the slip wait in clock cycles
`define PXG_LOCK_GOOD     7'h40
`define PXG_BAD_WINDOW    7'h40
`define PXG_BAD_LIMIT     7'h10
`define PXG_SLIP_WAIT     7'h40

// Status reset value, FIFO depth and transmit ready margin
`define PXG_STATUS_RST    8'h00
`define PXG_FIFO_DEPTH    16
`define PXG_TX_MARGIN     4

`endif

// ===== design/pxg_pkg.sv
// Purpose: Shared types for the client/transceiver alignment block
// Assumes: Constants come from pxg_map.svh
// Notes:   State codes are one-hot
package pxg_pkg;

  // Receive block lock hunting
  typedef enum logic [2:0] {
    PXG_LK_HUNT   = 3'b001,
    PXG_LK_WAIT   = 3'b010,
    PXG_LK_LOCKED = 3'b100
  } pxg_lock_st_t;

  // Configuration front end chosen at build time; only one may exist
  typedef enum logic [1:0] {
    PXG_CFG_SERIAL = 2'b01,
    PXG_CFG_VECTOR = 2'b10
  } pxg_cfg_if_t;

  typedef logic [63:0] pxg_word_t;
  typedef logic [7:0]  pxg_ctl_t;

endpackage : pxg_pkg

// ===== design/pxg_link_if.sv
// Purpose: Joins the alignment block to its client and transceiver partner
// Assumes: Both ends run on one clock
// Notes:   No clocking block; the bench connects clk and the two modports
`timescale 1ns/1ps
`default_nettype none
interface pxg_link_if;
  pxg_pkg::pxg_word_t cl_tx_data;     // Client transmit word
  pxg_pkg::pxg_ctl_t  cl_tx_ctrl;     // Client transmit lane controls
  logic               cl_tx_valid;    // Client transmit word valid
  logic               cl_tx_ready;    // Block can take more words
  pxg_pkg::pxg_word_t cl_rx_data;     // Client receive word
  pxg_pkg::pxg_ctl_t  cl_rx_ctrl;     // Client receive lane controls
  logic               cl_rx_valid;    // Client receive word valid
  pxg_pkg::pxg_word_t xcvr_tx_word;   // Transmit word toward the transceiver
  pxg_pkg::pxg_ctl_t  xcvr_tx_ctrl;   // Sync header and sequence count
  pxg_pkg::pxg_word_t xcvr_rx_word;   // Receive word from the transceiver
  pxg_pkg::pxg_ctl_t  xcvr_rx_ctrl;   // Sync header and data-valid qualifier
  logic               xcvr_align_slip; // One-cycle slip request

  modport dev (
    input  cl_tx_data, cl_tx_ctrl, cl_tx_valid, xcvr_rx_word, xcvr_rx_ctrl,
    output cl_tx_ready, cl_rx_data, cl_rx_ctrl, cl_rx_valid,
    output xcvr_tx_word, xcvr_tx_ctrl, xcvr_align_slip
  );
  modport far (
    output cl_tx_data, cl_tx_ctrl, cl_tx_valid, xcvr_rx_word, xcvr_rx_ctrl,
    input  cl_tx_ready, cl_rx_data, cl_rx_ctrl, cl_rx_valid,
    input  xcvr_tx_word, xcvr_tx_ctrl, xcvr_align_slip
  );
endinterface : pxg_link_if
`default_nettype wire

// ===== design/pxg_fifo.sv
// Purpose: Word FIFO with valid/ready on both sides
// Assumes: Single clock; simultaneous push and pop allowed
// Notes:   Level output lets the writer throttle ahead of full
`timescale 1ns/1ps
`default_nettype none
module pxg_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,       // System clock
  input  wire logic             arst_n,    // Async reset, active low
  input  wire logic [WIDTH-1:0] in_data,   // Write word
  input  wire logic             in_valid,  // Write request
  output logic                  in_ready,  // Not full
  output logic [WIDTH-1:0]      out_data,  // Head word
  output logic                  out_valid, // Not empty
  input  wire logic             out_ready, // Reader takes head
  output logic [$clog2(DEPTH):0] level     // Words held
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // Full and empty from the count
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q];
  assign level     = cnt_q;

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers wrap at DEPTH, so any depth works
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : pxg_fifo
`default_nettype wire

// ===== design/pxg_far_end.sv
// Purpose: Client and transceiver partner end of the alignment link
// Assumes: Line side words arrive on the system clock
// Notes:   Adds the data-valid cadence and checks client framing
`timescale 1ns/1ps
`default_nettype none
`include "pxg_map.svh"
module pxg_far_end (
  input  wire logic               clk,             // System clock
  input  wire logic               arst_n,          // Async reset, active low
  pxg_link_if.far                 link,            // Link to the device end
  input  wire pxg_pkg::pxg_word_t usr_tx_data,     // Client transmit word
  input  wire pxg_pkg::pxg_ctl_t  usr_tx_ctrl,     // Client lane controls
  input  wire logic               usr_tx_valid,    // Client word valid
  output logic                    usr_tx_ready,    // Client may present words
  output logic                    usr_tx_frame_err, // Sticky framing fault seen
  output pxg_pkg::pxg_word_t      usr_rx_data,     // Received client word
  output pxg_pkg::pxg_ctl_t       usr_rx_ctrl,     // Received lane controls
  output logic                    usr_rx_valid,    // Received word valid
  output pxg_pkg::pxg_word_t      line_tx_word,    // Word toward the line
  output logic [1:0]              line_tx_hdr,     // Sync header toward the line
  output logic [5:0]              line_tx_seq,     // Gearbox sequence
  input  wire pxg_pkg::pxg_word_t line_rx_word,    // Word from the line
  input  wire logic [1:0]         line_rx_hdr,     // Sync header from the line
  output logic                    line_slip        // Slip request to the line
);
  import pxg_pkg::*;

  logic [5:0] vcnt_q;
  logic [7:0] bad_start;
  logic [7:0] term_at;
  logic [7:0] non_idle;
  logic [7:0] above_term;
  logic       frame_bad;

  // Per-lane framing checks on what the client presents
  for (genvar n = 0; n < `PXG_LANES; n++) begin : g_lane
    logic [7:0] b;
    assign b = usr_tx_data[8*n+7 -: 8];
    assign bad_start[n] = usr_tx_ctrl[n] && (b == `PXG_CH_START) &&
                          (n != 0) && (n != 4);                       // [RULE8]
    assign term_at[n]  = usr_tx_ctrl[n] && (b == `PXG_CH_TERM);
    assign non_idle[n] = !(usr_tx_ctrl[n] && (b == `PXG_CH_IDLE));
    if (n == 0) begin : g_first
      assign above_term[n] = 1'b0;
    end else begin : g_rest
      assign above_term[n] = above_term[n-1] | term_at[n-1];
    end
  end
  assign frame_bad = |bad_start | |(above_term & non_idle);            // [RULE9]

  // Client transmit: one register stage, ready a cycle late
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link.cl_tx_data  <= '0;
      link.cl_tx_ctrl  <= '0;
      link.cl_tx_valid <= 1'b0;
      usr_tx_ready     <= 1'b0;
      usr_tx_frame_err <= 1'b0;
    end else begin
      link.cl_tx_data  <= usr_tx_data;                                 // [RULE1] [RULE2] [RULE3]
      link.cl_tx_ctrl  <= usr_tx_ctrl;                                 // [RULE4] [RULE5]
      link.cl_tx_valid <= usr_tx_valid & usr_tx_ready;
      usr_tx_ready     <= link.cl_tx_ready;
      if (usr_tx_valid && usr_tx_ready && frame_bad) begin
        usr_tx_frame_err <= 1'b1;
      end
    end
  end

  // Qualifier low one cycle in 33
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vcnt_q            <= '0;
      link.xcvr_rx_word <= '0;
      link.xcvr_rx_ctrl <= '0;
    end else begin
      vcnt_q            <= (vcnt_q == `PXG_VALID_MAX) ? '0 : vcnt_q + 6'h01;
      link.xcvr_rx_word <= line_rx_word;                                // [RULE15] [RULE17]
      link.xcvr_rx_ctrl <= {5'h00, (vcnt_q != `PXG_VALID_MAX), line_rx_hdr}; // [RULE16]
    end
  end

  // Line transmit and client receive registered straight through
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      line_tx_word <= '0;
      line_tx_hdr  <= '0;
      line_tx_seq  <= '0;
      line_slip    <= 1'b0;
      usr_rx_data  <= '0;
      usr_rx_ctrl  <= '0;
      usr_rx_valid <= 1'b0;
    end else begin
      line_tx_word <= link.xcvr_tx_word;
      line_tx_hdr  <= link.xcvr_tx_ctrl[`PXG_HDR_MSB:`PXG_HDR_LSB];
      line_tx_seq  <= link.xcvr_tx_ctrl[`PXG_SEQ_MSB:`PXG_SEQ_LSB];
      line_slip    <= link.xcvr_align_slip;
      usr_rx_data  <= link.cl_rx_data;
      usr_rx_ctrl  <= link.cl_rx_ctrl;
      usr_rx_valid <= link.cl_rx_valid;
    end
  end
endmodule : pxg_far_end
`default_nettype wire

// ===== design/pxg_dev_end.sv
// What this block does
// (RULE1) Client word holds two 32-bit transfers
// (RULE2) Eight lanes; upper four go later
// (RULE3) Lane n is data bits 8n+7:8n
// (RULE4) Control bit index equals lane number
// (RULE5) Control bit set means control character
// (RULE6) Control 07 idle, FB start, FD terminate
// (RULE7) Error is FE with control set
// (RULE8) Client starts frames in lane 0 or 4
// (RULE9) Client terminates anywhere, idles above it
// (RULE10) Received start only in lane 0 or 4
// (RULE11) Received frames always closed by terminate
// (RULE12) Inbound errors become error characters; outside a frame a bad header gives idles
// (RULE13) Transmit word plus 2-bit sync header
// (RULE14) Sequence count on bits 7:2, 0..32
// (RULE15) Transceiver gives word and sync header
// (RULE16) Receive valid high 32 of 33
// (RULE17) 64 data plus 8 control bits each way
// (RULE18) Only one configuration interface per build
// (RULE19) Reset sampled on the system clock
// (RULE20) Status bit 0 is block lock
// (RULE21) Slip while unlocked, then wait
// (RULE22) Ignore receive beats without valid
//
// Purpose: Device end: client bus to sync-headed 64-bit gearbox words and back
// Assumes: Partner keeps the client framing and the valid cadence
// Notes:   Control blocks carry raw bytes; control lanes are recovered by value
`timescale 1ns/1ps
`default_nettype none
`include "pxg_map.svh"
module pxg_dev_end #(
  parameter pxg_pkg::pxg_cfg_if_t CFG_IF    = pxg_pkg::PXG_CFG_SERIAL,
  parameter int                   FIFO_DEPTH = `PXG_FIFO_DEPTH
) (
  input  wire logic clk,        // System clock, 100 MHz
  input  wire logic arst_n,     // Async reset, active low
  pxg_link_if.dev   link,       // Link to the partner end
  output logic       block_lock, // Receive block lock
  output logic [7:0] dev_status  // Status byte
);
  import pxg_pkg::*;

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // Exactly one configuration front end per build
  localparam logic CFG_ONE = (CFG_IF == PXG_CFG_SERIAL) ^ (CFG_IF == PXG_CFG_VECTOR); // [RULE18]

  logic         rst_meta_q;
  logic         rst_sync_q;
  logic [71:0]  f_out;
  logic         f_in_ready;
  logic         f_out_valid;
  logic         f_pop;
  logic [LW-1:0] f_level;
  logic [5:0]   seq_q;
  pxg_lock_st_t lk_q;
  logic [6:0]   good_q;
  logic [6:0]   beat_q;
  logic [6:0]   bad_q;
  logic [6:0]   wait_q;
  logic         in_frame_q;
  logic         beat;
  logic         hdr_good;
  logic [1:0]   hdr;
  pxg_word_t    dec_d;
  pxg_ctl_t     dec_c;
  pxg_word_t    blk_d;
  pxg_ctl_t     blk_c;
  logic [7:0]   has_start;
  logic [7:0]   has_term;
  logic         any_ctrl;

  // Async assert, release on a clock edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= CFG_ONE;                                           // [RULE19]
      rst_sync_q <= rst_meta_q;
    end
  end

  // Transmit queue; the pause slot lets it fill
  pxg_fifo #(.WIDTH(72), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk       (clk),
    .arst_n    (rst_sync_q),
    .in_data   ({link.cl_tx_ctrl, link.cl_tx_data}),
    .in_valid  (link.cl_tx_valid),
    .in_ready  (f_in_ready),
    .out_data  (f_out),
    .out_valid (f_out_valid),
    .out_ready (f_pop),
    .level     (f_level)
  );

  assign f_pop    = f_out_valid && (seq_q != `PXG_SEQ_MAX);
  assign any_ctrl = |f_out[71:64];

  // Ready keeps margin: the partner reacts late
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      link.cl_tx_ready <= 1'b0;
    end else begin
      link.cl_tx_ready <= f_in_ready &&
                          (f_level <= LW'(FIFO_DEPTH - `PXG_TX_MARGIN));
    end
  end

  // Word, header and count; word holds in the pause slot
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      seq_q             <= '0;
      link.xcvr_tx_word <= {8{`PXG_CH_IDLE}};
      link.xcvr_tx_ctrl <= {6'h00, `PXG_HDR_CTRL};
    end else begin
      seq_q <= (seq_q == `PXG_SEQ_MAX) ? '0 : seq_q + 6'h01;          // [RULE14]
      link.xcvr_tx_ctrl[`PXG_SEQ_MSB:`PXG_SEQ_LSB] <= seq_q;           // [RULE14] [RULE17]
      if (f_pop) begin
        link.xcvr_tx_word <= f_out[63:0];                              // [RULE13]
        link.xcvr_tx_ctrl[`PXG_HDR_MSB:`PXG_HDR_LSB] <=
          any_ctrl ? `PXG_HDR_CTRL : `PXG_HDR_DATA;                    // [RULE5] [RULE13]
      end else if (seq_q != `PXG_SEQ_MAX) begin
        link.xcvr_tx_word <= {8{`PXG_CH_IDLE}};                        // [RULE6]
        link.xcvr_tx_ctrl[`PXG_HDR_MSB:`PXG_HDR_LSB] <= `PXG_HDR_CTRL;
      end
    end
  end

  assign beat     = link.xcvr_rx_ctrl[`PXG_RXVALID_BIT];                // [RULE16] [RULE22]
  assign hdr      = link.xcvr_rx_ctrl[`PXG_HDR_MSB:`PXG_HDR_LSB];
  assign hdr_good = (hdr == `PXG_HDR_DATA) || (hdr == `PXG_HDR_CTRL);

  // Lanes recovered by value: a data byte equal to a code is misread
  for (genvar n = 0; n < `PXG_LANES; n++) begin : g_lane
    logic [7:0] b;
    logic       c;
    assign b = link.xcvr_rx_word[8*n+7 -: 8];                          // [RULE3]
    assign c = (hdr == `PXG_HDR_CTRL) &&
               ((b == `PXG_CH_IDLE) || (b == `PXG_CH_START) ||
                (b == `PXG_CH_TERM) || (b == `PXG_CH_ERROR));          // [RULE4] [RULE6]
    assign has_start[n] = c && (b == `PXG_CH_START);
    assign has_term[n]  = c && (b == `PXG_CH_TERM);
    // A start outside lanes 0 and 4 is turned into an error character
    assign blk_d[8*n+7 -: 8] = (has_start[n] && (n != 0) && (n != 4)) ?
                               `PXG_CH_ERROR : b;                      // [RULE10] [RULE12]
    assign blk_c[n] = c;
  end

  // Choose what the client sees for one valid beat
  always_comb begin
    dec_d = blk_d;
    dec_c = blk_c;
    if (lk_q != PXG_LK_LOCKED) begin
      dec_d = {8{`PXG_CH_IDLE}};
      dec_c = 8'hFF;
      if (in_frame_q) begin
        dec_d[7:0] = `PXG_CH_TERM;                                     // [RULE11]
      end
    end else if (!hdr_good) begin
      dec_d = in_frame_q ? {8{`PXG_CH_ERROR}} : {8{`PXG_CH_IDLE}};     // [RULE7] [RULE12]
      dec_c = 8'hFF;
    end
  end

  // Client receive; beats without valid are dropped
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      link.cl_rx_data  <= {8{`PXG_CH_IDLE}};
      link.cl_rx_ctrl  <= 8'hFF;
      link.cl_rx_valid <= 1'b0;
      in_frame_q       <= 1'b0;
    end else begin
      link.cl_rx_valid <= beat;                                        // [RULE22]
      if (beat) begin
        link.cl_rx_data <= dec_d;                                      // [RULE1] [RULE2]
        link.cl_rx_ctrl <= dec_c;
        if (lk_q != PXG_LK_LOCKED) begin
          in_frame_q <= 1'b0;                                          // [RULE11]
        end else if (hdr_good) begin
          if (has_start[0] || has_start[4]) begin
            in_frame_q <= 1'b1;                                        // [RULE10]
          end else if (|has_term) begin
            in_frame_q <= 1'b0;
          end
        end
      end
    end
  end

  // Lock hunt: slip on a bad header, settle, retry
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      lk_q                 <= PXG_LK_HUNT;
      good_q               <= '0;
      beat_q               <= '0;
      bad_q                <= '0;
      wait_q               <= '0;
      link.xcvr_align_slip <= 1'b0;
    end else begin
      link.xcvr_align_slip <= 1'b0;
      case (lk_q)
        PXG_LK_HUNT: begin
          if (beat && hdr_good) begin
            good_q <= good_q + 7'h01;
            if (good_q == `PXG_LOCK_GOOD - 7'h01) begin
              lk_q   <= PXG_LK_LOCKED;
              beat_q <= '0;
              bad_q  <= '0;
            end
          end else if (beat) begin
            link.xcvr_align_slip <= 1'b1;                              // [RULE21]
            good_q               <= '0;
            wait_q               <= `PXG_SLIP_WAIT;
            lk_q                 <= PXG_LK_WAIT;
          end
        end
        PXG_LK_WAIT: begin
          wait_q <= wait_q - 7'h01;
          if (wait_q == 7'h01) begin
            lk_q <= PXG_LK_HUNT;                                       // [RULE21]
          end
        end
        PXG_LK_LOCKED: begin
          if (beat) begin
            beat_q <= (beat_q == `PXG_BAD_WINDOW - 7'h01) ? '0 : beat_q + 7'h01;
            if (!hdr_good && (bad_q == `PXG_BAD_LIMIT - 7'h01)) begin
              lk_q   <= PXG_LK_HUNT;
              good_q <= '0;
            end else if (beat_q == `PXG_BAD_WINDOW - 7'h01) begin
              bad_q <= '0;
            end else if (!hdr_good) begin
              bad_q <= bad_q + 7'h01;
            end
          end
        end
        default: begin
          lk_q <= PXG_LK_HUNT;
        end
      endcase
    end
  end

  // Status byte: lock on bit 0, other bits reserved at zero
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      block_lock <= 1'b0;
      dev_status <= `PXG_STATUS_RST;
    end else begin
      block_lock <= (lk_q == PXG_LK_LOCKED);
      dev_status <= {7'h00, (lk_q == PXG_LK_LOCKED)};                  // [RULE20]
    end
  end
endmodule : pxg_dev_end
`default_nettype wire

// ===== testbench/pxg_link_chk_sva.sv
// Purpose: Concurrent checks on the link that joins the two ends
// Assumes: One clock; arst_n active low
// Notes:   A short guard skips the edges of the device's reset synchroniser
`timescale 1ns/1ps
`default_nettype none
module pxg_link_chk (
  input wire logic               clk,             // System clock
  input wire logic               arst_n,          // Async reset, active low
  input wire pxg_pkg::pxg_word_t xcvr_tx_word,    // Line transmit word
  input wire pxg_pkg::pxg_ctl_t  xcvr_tx_ctrl,    // Header and sequence
  input wire pxg_pkg::pxg_ctl_t  xcvr_rx_ctrl,    // Header and valid
  input wire pxg_pkg::pxg_word_t xcvr_rx_word,    // Line receive word
  input wire logic               xcvr_align_slip, // Slip pulse
  input wire pxg_pkg::pxg_word_t cl_rx_data,      // Client receive word
  input wire pxg_pkg::pxg_ctl_t  cl_rx_ctrl,      // Client receive controls
  input wire logic               cl_rx_valid,     // Client receive valid
  input wire logic               block_lock,      // Receive lock
  input wire logic [7:0]         dev_status       // Status byte
);
  import pxg_pkg::*;
  logic [2:0] age_q;
  logic       live;
  logic       odd_start;
  // Edges since release; the device wakes two edges late
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  end
  assign live = (age_q > 3'h4);
  // Start code in a lane other than 0 or 4
  always_comb begin
    odd_start = 1'b0;
    for (int n = 1; n < 8; n++)
      if (n != 4 && cl_rx_ctrl[n] && cl_rx_data[8*n +: 8] == 8'hFB) odd_start = 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  seq_range_a: assert property (xcvr_tx_ctrl[7:2] <= 6'h20)
    else $error("sequence count above 32");
  seq_step_a: assert property (live && $past(live) |-> xcvr_tx_ctrl[7:2] ==
    (($past(xcvr_tx_ctrl[7:2]) == 6'h20) ? 6'h00 : $past(xcvr_tx_ctrl[7:2]) + 6'h01))
    else $error("sequence count stepped wrongly");
  hdr_legal_a: assert property (xcvr_tx_ctrl[1:0] inside {2'h1, 2'h2})
    else $error("illegal sync header");
  pause_hold_a: assert property (live && xcvr_tx_ctrl[7:2] == 6'h20 |-> $stable(xcvr_tx_word))
    else $error("word moved in pause slot");
  slip_once_a: assert property ($rose(xcvr_align_slip) |=> !xcvr_align_slip [*8])
    else $error("slip not a single pulse");
  slip_unlk_a: assert property (xcvr_align_slip |-> !block_lock)
    else $error("slip while locked");
  rx_gated_a: assert property (live && cl_rx_valid |-> $past(xcvr_rx_ctrl[2]))
    else $error("receive beat without valid");
  rx_data_a: assert property (live && block_lock && $past(block_lock) &&
    $past(xcvr_rx_ctrl[2]) && $past(xcvr_rx_ctrl[1:0]) == 2'h1 |->
    cl_rx_valid && cl_rx_ctrl == 8'h00 && cl_rx_data == $past(xcvr_rx_word))
    else $error("data block not passed through");
  rx_unlk_a: assert property (!block_lock && cl_rx_valid |-> cl_rx_ctrl == 8'hFF)
    else $error("unlocked output not control");
  rx_start_a: assert property (cl_rx_valid |-> !odd_start)
    else $error("start code in wrong lane");
  status_a: assert property (dev_status == {7'h00, block_lock})
    else $error("status byte wrong");
  slip_seen_c: cover property ($rose(xcvr_align_slip));
  lock_seen_c: cover property ($rose(block_lock));
  start_seen_c: cover property (cl_rx_valid && cl_rx_ctrl[0] && cl_rx_data[7:0] == 8'hFB);
endmodule : pxg_link_chk
`default_nettype wire

// ===== testbench/pxg_link_tb.sv
// Purpose: Drives the user transmit side and the line input, checks words end to end
// Assumes: Receive beats repeat while a line word is held, so repeats are dropped
// Notes:   Idle control blocks and pause slots are not compared
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module pxg_link_tb;
  import pxg_pkg::*;
  logic        clk, arst_n, tx_valid, tx_ready, frame_err, rx_valid, slip, block_lock;
  pxg_word_t   tx_data, rx_data, ln_tx_word, ln_rx_word;
  pxg_ctl_t    tx_ctrl, rx_ctrl;
  logic [7:0]  status;
  logic [1:0]  ln_tx_hdr, ln_rx_hdr;
  logic [5:0]  ln_tx_seq;
  logic [65:0] txq[$];
  logic [71:0] rxq[$];
  logic [71:0] last_q = '0;
  int          n_errors = 0, checks_done = 0, cyc = 0, slips = 0, stalls = 0;
  pxg_link_if lnk ();
  pxg_dev_end pxg_dev_end_inst (.clk(clk), .arst_n(arst_n), .link(lnk.dev),
    .block_lock(block_lock), .dev_status(status));
  pxg_far_end pxg_far_end_inst (.clk(clk), .arst_n(arst_n), .link(lnk.far),
    .usr_tx_data(tx_data), .usr_tx_ctrl(tx_ctrl), .usr_tx_valid(tx_valid),
    .usr_tx_ready(tx_ready), .usr_tx_frame_err(frame_err), .usr_rx_data(rx_data),
    .usr_rx_ctrl(rx_ctrl), .usr_rx_valid(rx_valid), .line_tx_word(ln_tx_word),
    .line_tx_hdr(ln_tx_hdr), .line_tx_seq(ln_tx_seq), .line_rx_word(ln_rx_word),
    .line_rx_hdr(ln_rx_hdr), .line_slip(slip));
  pxg_link_chk pxg_link_chk_inst (.clk(clk), .arst_n(arst_n),
    .xcvr_tx_word(lnk.xcvr_tx_word), .xcvr_tx_ctrl(lnk.xcvr_tx_ctrl),
    .xcvr_rx_ctrl(lnk.xcvr_rx_ctrl), .xcvr_rx_word(lnk.xcvr_rx_word),
    .xcvr_align_slip(lnk.xcvr_align_slip), .cl_rx_data(lnk.cl_rx_data),
    .cl_rx_ctrl(lnk.cl_rx_ctrl), .cl_rx_valid(lnk.cl_rx_valid),
    .block_lock(block_lock), .dev_status(status));
  always #5 clk = ~clk;
  // Cycle ceiling, refused offers and slip pulses
  always @(posedge clk) begin
    cyc++;
    if (tx_valid && !tx_ready) stalls++;
    if (slip) slips++;
    if (cyc == 60000) begin
      n_errors++;
      conclude();
    end
  end
  // Line transmit side; held pause words and idle blocks carry nothing new
  always @(posedge clk) begin
    if (cyc > 10 && ln_tx_seq != 6'h20 && !(ln_tx_hdr == 2'h2 && ln_tx_word == {8{8'h07}}))
    begin
      if (txq.size() == 0) `CHK(1'b0, 1'b1)
      else `CHK({ln_tx_hdr, ln_tx_word}, txq.pop_front())
    end
  end
  // Client receive side; repeats come from a held line word
  always @(posedge clk) begin
    if (rx_valid && {rx_ctrl, rx_data} != {8'hFF, {8{8'h07}}} && {rx_ctrl, rx_data} != last_q)
    begin
      last_q = {rx_ctrl, rx_data};
      if (rxq.size() == 0) `CHK(1'b0, 1'b1)
      else `CHK(last_q, rxq.pop_front())
    end
  end
  // Code at lane k; payload on one side avoids every code value
  function automatic logic [71:0] edge_word(input int k, input logic [7:0] cd, input logic up);
    logic [71:0] r;
    for (int n = 0; n < 8; n++) begin
      if (n == k) {r[64+n], r[8*n +: 8]} = {1'b1, cd};
      else if ((n > k) == up) {r[64+n], r[8*n +: 8]} = {5'h01, 4'($urandom)};
      else {r[64+n], r[8*n +: 8]} = 9'h107;
    end
    return r;
  endfunction : edge_word
  // Client word, held until the far end takes it
  task automatic put(input pxg_word_t w, input pxg_ctl_t c);
    logic ok;
    tx_data = w;
    tx_ctrl = c;
    tx_valid = 1'b1;
    do begin
      ok = tx_ready;
      @(posedge clk);
      #1;
    end while (ok !== 1'b1);
    txq.push_back({(c == 8'h00) ? 2'h1 : 2'h2, w});
  endtask : put
  // Line word, held until a valid beat has carried it into the device
  task automatic rx_put(input pxg_word_t w, input logic [1:0] h, input logic [71:0] e);
    logic ok;
    ln_rx_word = w;
    ln_rx_hdr = h;
    rxq.push_back(e);
    do begin
      ok = lnk.xcvr_rx_ctrl[2] && lnk.xcvr_rx_word === w && lnk.xcvr_rx_ctrl[1:0] === h;
      @(posedge clk);
      #1;
    end while (!ok);
  endtask : rx_put
  // Start in lane s, random data, terminate in lane k; one word may be corrupted
  task automatic frame(input int len, input int s, input int k, input logic rx, input logic err);
    logic [71:0] r;
    for (int i = 0; i < len; i++) begin
      if (i == 0) r = edge_word(s, 8'hFB, 1'b1);
      else if (i == len - 1) r = edge_word(k, 8'hFD, 1'b0);
      else r = {8'h00, $urandom, $urandom};
      if (!rx) put(r[63:0], r[71:64]);
      else if (err && i == 2) rx_put(r[63:0], 2'h3, {8'hFF, {8{8'hFE}}});
      else rx_put(r[63:0], (r[71:64] == 8'h00) ? 2'h1 : 2'h2, r);
    end
  endtask : frame
  task automatic conclude();
    $display("Comparisons %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    {clk, arst_n, tx_valid, tx_data, tx_ctrl, ln_rx_word, ln_rx_hdr} = '0;
    void'($urandom(2));
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (150) @(posedge clk);
    #1 `CHK(slips > 0, 1'b1)
    ln_rx_word = {8{8'h07}};
    ln_rx_hdr = 2'h2;
    for (int i = 0; i < 2000 && block_lock !== 1'b1; i++) @(posedge clk);
    #1 `CHK(status, 8'h01)
    for (int f = 0; f < 12; f++) frame(50, (f % 2) * 4, f % 8, 1'b0, 1'b0);
    tx_valid = 1'b0;
    repeat (100) @(posedge clk);
    #1 `CHK(txq.size() == 0 && stalls > 0, 1'b1)
    `CHK(frame_err, 1'b0)
    for (int f = 0; f < 8; f++) frame(6, (f % 2) * 4, f, 1'b1, f == 3);
    ln_rx_word = {8{8'h07}};
    ln_rx_hdr = 2'h2;
    repeat (20) @(posedge clk);
    #1 `CHK(rxq.size() == 0, 1'b1)
    ln_rx_hdr = 2'h0;
    repeat (60) @(posedge clk);
    `CHK(block_lock, 1'b0)
    conclude();
  end
endmodule : pxg_link_tb
`default_nettype wire
